// ---- rtl/fb_path_pkg.sv ----
// Shared constants and types for the dual feedback position path
package fb_path_pkg;

  // ==========================================================
  // Register map (byte addresses on the APB)
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] GEAR_NUM_OFS = 8'h04;
  localparam logic [7:0] GEAR_DEN_OFS = 8'h08;
  localparam logic [7:0] FILTER_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] MOTOR_GR_OFS = 8'h14;
  localparam logic [7:0] LOAD_CUM_OFS = 8'h18;
  localparam logic [7:0] LOAD_INF_OFS = 8'h1c;
  localparam logic [7:0] BLEND_OFS    = 8'h20;
  localparam logic [7:0] HOME_POS_OFS = 8'h24;
  localparam logic [7:0] MOTOR_RW_OFS = 8'h28;

  // ==========================================================
  // Control field positions
  localparam int CTRL_OPMODE_BIT = 0;
  localparam int CTRL_LOOPSEL_BIT = 1;
  localparam int CTRL_SWITCH_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_HOME_BIT = 8;
  localparam int CTRL_CLR_BIT = 9;

  // ==========================================================
  // Reset values and filter figures
  localparam logic [15:0] GEAR_RST  = 16'h0001;
  localparam logic [12:0] FILT_RST  = 13'h000a;   // 10
  localparam logic [12:0] FILT_SEMI = 13'h0000;   // 0
  localparam logic [12:0] FILT_FULL = 13'h1194;   // 4500
  localparam int          BLEND_SHIFT = 24;
  localparam logic [12:0] BLEND_RECIP = 13'h0e90; // 2^24/4500

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    LOOP_SEMI = 2'h0,
    LOOP_DUAL = 2'h1,
    LOOP_FULL = 2'h2
  } loopMode_t;

  typedef enum logic [4:0] {
    HOME_IDLE   = 5'h01,
    HOME_ARMED  = 5'h02,
    HOME_MARKED = 5'h04,
    HOME_DONE   = 5'h08,
    HOME_FAIL   = 5'h10
  } homeState_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser with edge detection for a group of pins
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk, // System clock
  input  wire logic         sys_rst,  // Synchronous reset, high
  input  wire logic [W-1:0] pinRaw,   // Asynchronous pins
  output logic      [W-1:0] pinLevel, // Synchronised level
  output logic      [W-1:0] pinRise,  // One-cycle rising edge
  output logic      [W-1:0] pinFall   // One-cycle falling edge
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } syncState_t;

  syncState_t state_q;
  syncState_t state_d;

  // ==========================================================
  // Shift chain; only the second stage reads the first
  always_comb begin
    state_d    = state_q;
    state_d.s1 = pinRaw;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Edges from the settled stages
  assign pinLevel = state_q.s2;
  assign pinRise  = state_q.s2 & ~state_q.s3;
  assign pinFall  = ~state_q.s2 & state_q.s3;

endmodule // pin_sync

// ---- rtl/dual_feedback_path.sv ----
// Dual feedback position path: gear, load count, blend, home return
module dual_feedback_path
  import fb_path_pkg::*;
(
  input  wire logic        core_clk,   // System clock, 100 MHz
  input  wire logic        sys_rst,    // Synchronous reset, high
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB write
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error, unmapped address
  input  wire logic        motorStep,  // Motor encoder count pulse
  input  wire logic        motorDir,   // Motor direction, high is CCW
  input  wire logic        loadStep,   // Load encoder count pulse
  input  wire logic        loadDir,    // Load direction, high is up
  input  wire logic        loadIndex,  // Load reference mark or Z-phase
  input  wire logic        dogIn,      // Proximity dog, high while on
  input  wire logic        encFault,   // Load encoder alarm level
  output logic      [31:0] blendFb,    // Blended position feedback
  output logic      [1:0]  loopMode,   // Effective control mode
  output logic             homeDone,   // Home return finished
  output logic             homeFail    // Home return failed
);

  typedef struct packed {
    logic              opFull;
    logic              loopSel;
    logic              switchCmd;
    logic              polarity;
    logic [15:0]       numA;
    logic [15:0]       numB;
    logic [15:0]       denA;
    logic [15:0]       denB;
    logic [12:0]       filt;
    logic signed [33:0] resid;
    logic [31:0]       motorRaw;
    logic [31:0]       motorGeared;
    logic [31:0]       loadCum;
    logic [31:0]       loadInfo;
    logic [31:0]       blend;
    logic [31:0]       homePos;
    loopMode_t         mode;
    homeState_t        home;
    logic [31:0]       rdata;
    logic              rdValid;
    logic              rdErr;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ==========================================================
  // Pin synchronisers
  logic [6:0] pinLevel;
  logic [6:0] pinRise;
  logic [6:0] pinFall;

  pin_sync #(
    .W (7)
  ) u_pins (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pinRaw   ({encFault, dogIn, loadIndex, loadDir, loadStep,
                motorDir, motorStep}),
    .pinLevel (pinLevel),
    .pinRise  (pinRise),
    .pinFall  (pinFall)
  );

  logic mStepEv;
  logic mDirLvl;
  logic lStepEv;
  logic lDirLvl;
  logic idxEv;
  logic dogOffEv;
  logic faultLvl;

  assign mStepEv  = pinRise[0];
  assign mDirLvl  = pinLevel[1];
  assign lStepEv  = pinRise[2];
  assign lDirLvl  = pinLevel[3];
  assign idxEv    = pinRise[4];
  assign dogOffEv = pinFall[5];
  assign faultLvl = pinLevel[6];

  // ==========================================================
  // Gear products and blend arithmetic
  logic [31:0]        gearNum;
  logic [31:0]        gearDen;
  logic signed [31:0] fbDiff;
  logic signed [59:0] blendProd;

  assign gearNum   = state_q.numA * state_q.numB;
  assign gearDen   = state_q.denA * state_q.denB;
  assign fbDiff    = $signed(state_q.loadCum - state_q.motorGeared);
  assign blendProd = fbDiff * $signed({1'b0, state_q.filt})
                     * $signed({1'b0, BLEND_RECIP});

  // ==========================================================
  // APB decode helpers
  logic        setupPh;
  logic        wrEn;
  logic        mapped;
  logic [31:0] rdMux;

  assign setupPh = psel && !penable;
  assign wrEn    = psel && penable && pwrite && state_q.rdValid;

  // Read mux and address check
  always_comb begin
    rdMux  = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      CTRL_OFS: begin
        rdMux[CTRL_OPMODE_BIT]  = state_q.opFull;
        rdMux[CTRL_LOOPSEL_BIT] = state_q.loopSel;
        rdMux[CTRL_SWITCH_BIT]  = state_q.switchCmd;
        rdMux[CTRL_POL_BIT]     = state_q.polarity;
      end
      GEAR_NUM_OFS: rdMux = {state_q.numB, state_q.numA};
      GEAR_DEN_OFS: rdMux = {state_q.denB, state_q.denA};
      FILTER_OFS:   rdMux = {19'h0_0000, state_q.filt};
      STATUS_OFS:   rdMux = {23'h00_0000,
                             state_q.home == HOME_DONE,
                             state_q.home == HOME_FAIL,
                             state_q.home, state_q.mode};
      MOTOR_GR_OFS: rdMux = state_q.motorGeared;
      LOAD_CUM_OFS: rdMux = state_q.loadCum;
      LOAD_INF_OFS: rdMux = state_q.loadInfo;
      BLEND_OFS:    rdMux = state_q.blend;
      HOME_POS_OFS: rdMux = state_q.homePos;
      MOTOR_RW_OFS: rdMux = state_q.motorRaw;
      default:      mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Next-state logic
  logic signed [33:0] residNext;
  logic signed [33:0] numS;
  logic signed [33:0] denS;
  logic [31:0]        loadStepVal;
  logic               homeStart;

  always_comb begin
    state_d     = state_q;
    numS        = $signed({2'b00, gearNum});
    denS        = $signed({2'b00, gearDen});
    residNext   = state_q.resid;
    loadStepVal = 32'h0000_0000;
    homeStart   = 1'b0;

    // Bus handshake: read data captured in setup, ready in access
    state_d.rdValid = setupPh;
    if (setupPh) begin
      state_d.rdata = pwrite ? 32'h0000_0000 : rdMux;
      state_d.rdErr = !mapped;
    end

    // Motor raw count and fractional gear residue
    if (mStepEv) begin
      state_d.motorRaw = mDirLvl ? state_q.motorRaw + 32'h1
                                 : state_q.motorRaw - 32'h1;
      residNext = mDirLvl ? state_q.resid + numS
                          : state_q.resid - numS;
    end
    // Emit one geared count per cycle while residue spans a unit
    if (gearDen != 32'h0000_0000) begin
      if (residNext >= denS) begin
        residNext = residNext - denS;
        state_d.motorGeared = state_q.motorGeared + 32'h1;
      end else if (residNext <= -denS) begin
        residNext = residNext + denS;
        state_d.motorGeared = state_q.motorGeared - 32'h1;
      end
    end
    state_d.resid = residNext;

    // Load cumulative count, polarity applied, held while faulted
    if (lStepEv && !faultLvl) begin
      loadStepVal = (lDirLvl ^ state_q.polarity) ? 32'h0000_0001
                                                 : 32'hffff_ffff;
      state_d.loadCum = state_q.loadCum + loadStepVal;
    end
    // Load info clears on each mark; the mark wins over a step
    if (idxEv) begin
      state_d.loadInfo = 32'h0000_0000;
    end else begin
      state_d.loadInfo = state_q.loadInfo + loadStepVal;
    end

    // Effective control mode from mode selects and filter
    if (!state_q.opFull || (state_q.loopSel && !state_q.switchCmd)) begin
      state_d.mode = LOOP_SEMI;
    end else if (state_q.filt == FILT_SEMI) begin
      state_d.mode = LOOP_SEMI;
    end else if (state_q.filt >= FILT_FULL) begin
      state_d.mode = LOOP_FULL;
    end else begin
      state_d.mode = LOOP_DUAL;
    end

    // Blended feedback by mode
    case (state_q.mode)
      LOOP_SEMI: state_d.blend = state_q.motorGeared;
      LOOP_FULL: state_d.blend = state_q.loadCum;
      LOOP_DUAL: state_d.blend = state_q.motorGeared
                   + blendProd[BLEND_SHIFT+31:BLEND_SHIFT];
      default:   state_d.blend = state_q.motorGeared;
    endcase

    // Register writes
    if (wrEn) begin
      case (paddr)
        CTRL_OFS: begin
          state_d.opFull    = pwdata[CTRL_OPMODE_BIT];
          state_d.loopSel   = pwdata[CTRL_LOOPSEL_BIT];
          state_d.switchCmd = pwdata[CTRL_SWITCH_BIT];
          state_d.polarity  = pwdata[CTRL_POL_BIT];
          homeStart         = pwdata[CTRL_HOME_BIT];
          if (pwdata[CTRL_CLR_BIT]) begin
            state_d.motorRaw    = 32'h0000_0000;
            state_d.motorGeared = 32'h0000_0000;
            state_d.loadCum     = 32'h0000_0000;
            state_d.loadInfo    = 32'h0000_0000;
            state_d.resid       = '0;
          end
        end
        GEAR_NUM_OFS: begin
          state_d.numA = pwdata[15:0];
          state_d.numB = pwdata[31:16];
        end
        GEAR_DEN_OFS: begin
          state_d.denA = pwdata[15:0];
          state_d.denB = pwdata[31:16];
        end
        FILTER_OFS: begin
          state_d.filt = (pwdata[12:0] > FILT_FULL) ? FILT_FULL
                                                    : pwdata[12:0];
        end
        default: begin
        end
      endcase
    end

    // Home return sequencer, load-side marks only
    case (state_q.home)
      HOME_IDLE, HOME_DONE, HOME_FAIL: begin
        if (homeStart) begin
          state_d.home = HOME_ARMED;
        end
      end
      HOME_ARMED: begin
        if (idxEv) begin
          state_d.homePos = state_q.loadCum;
          state_d.home = dogOffEv ? HOME_DONE : HOME_MARKED;
        end else if (dogOffEv) begin
          state_d.home = HOME_FAIL;
        end
      end
      HOME_MARKED: begin
        if (dogOffEv) begin
          state_d.home = HOME_DONE;
        end
      end
      default: state_d.home = HOME_IDLE;
    endcase
    if (homeStart && state_q.home != HOME_IDLE
        && state_q.home != HOME_DONE && state_q.home != HOME_FAIL) begin
      state_d.home = HOME_ARMED;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q      <= '0;
      state_q.numA <= GEAR_RST;
      state_q.numB <= GEAR_RST;
      state_q.denA <= GEAR_RST;
      state_q.denB <= GEAR_RST;
      state_q.filt <= FILT_RST;
      state_q.mode <= LOOP_SEMI;
      state_q.home <= HOME_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata   = state_q.rdata;
  assign pready   = state_q.rdValid;
  assign pslverr  = state_q.rdValid && state_q.rdErr;
  assign blendFb  = state_q.blend;
  assign loopMode = state_q.mode;
  assign homeDone = state_q.home == HOME_DONE;
  assign homeFail = state_q.home == HOME_FAIL;

endmodule // dual_feedback_path

// ---- bench/fb_path_sva.sv ----
// Port checker for the dual feedback position path
module fb_path_sva
  import fb_path_pkg::*;
(
  input wire logic       core_clk, // Clock
  input wire logic       sys_rst,  // Reset, high
  input wire logic       psel,     // Select
  input wire logic       penable,  // Access phase
  input wire logic       pwrite,   // Write
  input wire logic [7:0] paddr,    // Address
  input wire logic       pready,   // Ready
  input wire logic       pslverr,  // Error
  input wire logic       dogIn,    // Dog level
  input wire logic [1:0] loopMode, // Mode
  input wire logic       homeDone, // Done
  input wire logic       homeFail  // Fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Bus timing
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready && psel)
    else $error("pslverr outside access");
  // ==========================================================
  // Mode and homing
  chk_mode_legal: assert property (loopMode != 2'h3)
    else $error("illegal loop mode");
  chk_mode_cause: assert property (!$stable(loopMode) |->
    $past(psel && pwrite, 1) || $past(psel && pwrite, 2))
    else $error("loop mode moved without a write");
  chk_home_excl: assert property (!(homeDone && homeFail))
    else $error("done and fail together");
  chk_fail_hold: assert property (homeFail && !psel |=> homeFail)
    else $error("home fail dropped on its own");
  chk_done_dog: assert property ($rose(homeDone) |-> !dogIn)
    else $error("home done while dog on");
  chk_fail_dog: assert property ($rose(homeFail) |-> !dogIn)
    else $error("home fail while dog on");
  cover property ($rose(homeDone));
  cover property ($rose(homeFail));
  cover property (loopMode == 2'h2);
endmodule // fb_path_sva

bind dual_feedback_path fb_path_sva u_chk (.core_clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .dogIn, .loopMode,
  .homeDone, .homeFail);

// ---- bench/load_enc_model.sv ----
// Behavioural load-side encoder driving count and mark pins
module load_enc_model (
  output logic      loadStep,  // Count pulse
  output logic      loadDir,   // Direction, high up
  output logic      loadIndex, // Reference mark
  input  wire logic core_clk   // Clock
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 3; // Cycles per level, raise for a slow encoder
  // Idle levels
  initial begin
    loadStep = 1'b0;
    loadDir = 1'b0;
    loadIndex = 1'b0;
  end
  // Step train, each level held for hold cycles
  task automatic move(input int n, input logic up);
    loadDir <= up;
    repeat (n) begin
      repeat (hold) @(posedge core_clk);
      loadStep <= 1'b1;
      repeat (hold) @(posedge core_clk);
      loadStep <= 1'b0;
    end
    repeat (hold) @(posedge core_clk);
  endtask
  // Cross the reference mark once
  task automatic mark();
    repeat (hold) @(posedge core_clk);
    loadIndex <= 1'b1;
    repeat (hold) @(posedge core_clk);
    loadIndex <= 1'b0;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule // load_enc_model

// ---- bench/dual_feedback_path_bench.sv ----
// Register-level testbench for the dual feedback position path
module dual_feedback_path_bench
  import fb_path_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, sys_rst, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, blendFb, rd;
  logic        pready, pslverr, motorStep, motorDir, dogIn, encFault;
  logic        loadStep, loadDir, loadIndex, homeDone, homeFail;
  logic [1:0]  loopMode;
  int          nErrors = 0;
  int          comparisons = 0;
  int          fv[5] = '{0, 1, 4499, 4500, 5000};
  logic [1:0]  fm[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

  dual_feedback_path u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .motorStep(motorStep), .motorDir(motorDir),
    .loadStep(loadStep), .loadDir(loadDir), .loadIndex(loadIndex),
    .dogIn(dogIn), .encFault(encFault), .blendFb(blendFb),
    .loopMode(loopMode), .homeDone(homeDone), .homeFail(homeFail));
  load_enc_model u_enc (.loadStep(loadStep), .loadDir(loadDir),
    .loadIndex(loadIndex), .core_clk(core_clk));

  // ==========================================================
  // Clock and helpers
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, waits for pready under a bound
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    check("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), exp, rd);
  endtask
  task automatic motor(input int n, input logic up);
    motorDir <= up;
    repeat (n) begin
      wt(3);
      motorStep <= 1'b1;
      wt(3);
      motorStep <= 1'b0;
    end
    wt(6);
  endtask
  task automatic finalReport();
    if (nErrors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200us;
    nErrors++;
    finalReport();
  end

  // ==========================================================
  // Test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {motorStep, motorDir, dogIn, encFault} = '0;
    sys_rst = 1'b1;
    wt(8);
    sys_rst <= 1'b0;
    rdc(FILTER_OFS, 32'h0000000a);
    rdc(GEAR_NUM_OFS, 32'h00010001);
    rdc(STATUS_OFS, 32'h00000004);
    xfer(1'b0, 8'h40, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    check("unmapped", 32'h0, rd);
    // Filter setting selects the loop mode
    xfer(1'b1, CTRL_OFS, 32'h1);
    foreach (fv[i]) begin
      xfer(1'b1, FILTER_OFS, fv[i]);
      wt(3);
      check("loopMode", {30'h0, fm[i]}, {30'h0, loopMode});
    end
    rdc(FILTER_OFS, 32'h00001194);
    xfer(1'b1, CTRL_OFS, 32'h3);
    wt(3);
    check("loopMode sw", 32'h0, {30'h0, loopMode});
    // Gear 3*2 over 2*2, motor and load moving together
    xfer(1'b1, GEAR_NUM_OFS, 32'h00020003);
    xfer(1'b1, GEAR_DEN_OFS, 32'h00020002);
    xfer(1'b1, CTRL_OFS, 32'h201);
    fork
      motor(4, 1'b1);
      u_enc.move(6, 1'b1);
    join
    rdc(MOTOR_RW_OFS, 32'h4);
    rdc(MOTOR_GR_OFS, 32'h6);
    rdc(LOAD_CUM_OFS, 32'h6);
    encFault <= 1'b1;
    u_enc.move(2, 1'b1);
    encFault <= 1'b0;
    rdc(LOAD_CUM_OFS, 32'h6);
    xfer(1'b1, CTRL_OFS, 32'h9);
    u_enc.move(2, 1'b1);
    rdc(LOAD_CUM_OFS, 32'h4);
    // Blend at the two end settings and at dual settings 10 and 4499
    wt(3);
    check("blend full", 32'h4, blendFb);
    xfer(1'b1, FILTER_OFS, 32'h0);
    wt(3);
    check("blend semi", 32'h6, blendFb);
    xfer(1'b1, FILTER_OFS, 32'ha);
    wt(3);
    check("blend dual 10", 32'h5, blendFb);
    xfer(1'b1, FILTER_OFS, 32'h1193);
    wt(3);
    check("blend dual 4499", 32'h4, blendFb);
    u_enc.mark();
    rdc(LOAD_INF_OFS, 32'h0);
    // Home return with the mark crossed, then without
    xfer(1'b1, CTRL_OFS, 32'h109);
    dogIn <= 1'b1;
    wt(4);
    rdc(STATUS_OFS, 32'h00000009);
    u_enc.move(1, 1'b1);
    motor(2, 1'b1);
    u_enc.mark();
    dogIn <= 1'b0;
    wt(6);
    check("homeDone", 32'h1, {31'h0, homeDone});
    rdc(HOME_POS_OFS, 32'h3);
    xfer(1'b1, CTRL_OFS, 32'h109);
    dogIn <= 1'b1;
    wt(6);
    dogIn <= 1'b0;
    wt(6);
    check("homeFail", 32'h1, {31'h0, homeFail});
    rdc(STATUS_OFS, 32'h000000c1);
    // Reset in mid-run restores defaults
    sys_rst <= 1'b1;
    wt(3);
    sys_rst <= 1'b0;
    rdc(FILTER_OFS, 32'h0000000a);
    rdc(STATUS_OFS, 32'h00000004);
    finalReport();
  end
endmodule // dual_feedback_path_bench
